// ==== sbcpt_edge_src.sv ====
// External signal source model for the capture/compare pin
`timescale 1ns/1ps

module sbcpt_edge_src #(
  parameter int HOLD_MIN = 2
) (
  input  wire logic core_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_in
);
  logic lvl_r = 1'b0;

  // ==========================================================
  // Pin level: the timer wins while it drives in PWM mode
  assign pin_in = pin_oe ? pin_out : lvl_r;

  // One level change, then held so the edge cannot be missed
  task automatic flip(input int hold);
    @(posedge core_clk);
    lvl_r <= ~lvl_r;
    repeat ((hold < HOLD_MIN) ? HOLD_MIN : hold) @(posedge core_clk);
  endtask : flip

endmodule : sbcpt_edge_src

// ==== sbcpt_pin_sync.sv ====
// Capture pin synchroniser and edge detector
`timescale 1ns/1ps

module sbcpt_pin_sync (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic pin_async,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  logic [1:0] sync_r;
  logic       prev_r;

  // ==========================================================
  // Two-flop synchroniser, then one more sample for comparison
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_r <= 2'h0;
      prev_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[0], pin_async};
      prev_r <= sync_r[1];
    end
  end

  // Edges from successive registered samples
  assign rise_pulse = sync_r[1] & ~prev_r;
  assign fall_pulse = ~sync_r[1] & prev_r;

endmodule : sbcpt_pin_sync

// ==== sbcpt_pkg.sv ====
// Constants shared by the 16-bit capture and PWM timer
package sbcpt_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int          CNT_W     = 16;
  localparam int          PRE_W     = 8;
  localparam int          ST_N      = 4;
  localparam logic [15:0] CNT_RST   = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [7:0]  PRE_RST   = 8'h00;
  localparam logic [7:0]  PRE_ZERO  = 8'h00;
  localparam logic [7:0]  PRE_ONE   = 8'h01;

  // ==========================================================
  // Configuration and mode encodings
  localparam logic [2:0]  CFG_SPLIT = 3'h4;
  localparam logic [1:0]  MODE_ONE  = 2'h1;
  localparam logic [1:0]  MODE_PER  = 2'h2;
  localparam logic [1:0]  MODE_CAP  = 2'h3;
  localparam logic [1:0]  EVT_RISE  = 2'h0;
  localparam logic [1:0]  EVT_FALL  = 2'h1;
  localparam logic [1:0]  EVT_BOTH  = 2'h3;

  // ==========================================================
  // Status bit positions
  localparam int          ST_CM     = 0;
  localparam int          ST_CE     = 1;
  localparam int          ST_TO     = 2;
  localparam int          ST_SP     = 3;

endpackage : sbcpt_pkg

// ==== sbcpt_timer.sv ====
// What this block does
// - A new interval load taken while running is adopted the next cycle.
// - Stall freeze holds the counter until it is released.
// - Prescale P stretches each decrement to P+1 clocks in timed modes.
// - Edge count, edge time and PWM modes bypass the prescaler.
// - Capture select low gives edge counting on rise, fall or both.
// - Each edge decrements by one; reaching match sets count match status.
// - On match the counter reloads, enable clears, later edges are ignored.
// - Capture select high gives free-running edge timing, one edge kind.
// - Each selected edge copies the count and sets capture status.
// - Edge time counter keeps running and reloads at zero.
// - The captured count holds until the next selected edge.
// - PWM counts down, reloads after zero, raises no status.
// - PWM goes active at the load value, inactive at the match value.
// - PWM invert flips the output polarity.
// - Timed modes reload at zero, one-shot disables, timeout status set.
// - Reset puts counter and load at 0xFFFF, prescale at 0x00.
`timescale 1ns/1ps

module sbcpt_timer (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [2:0]  split_config,
  input  wire logic [1:0]  timer_mode_field,
  input  wire logic        capture_mode_select,
  input  wire logic        alternate_mode_select,
  input  wire logic [1:0]  edge_event_select,
  input  wire logic        pwm_output_invert,
  input  wire logic        stall_freeze,
  input  wire logic        timer_enable_set,
  input  wire logic        timer_enable_clr,
  input  wire logic        interval_load_wr,
  input  wire logic [15:0] interval_load_wdata,
  input  wire logic        prescale_wr,
  input  wire logic [7:0]  prescale_wdata,
  input  wire logic [15:0] match_value,
  input  wire logic [3:0]  status_mask,
  input  wire logic [3:0]  status_clear,
  input  wire logic        capture_compare_pin_in,
  output logic             capture_compare_pin_out,
  output logic             capture_compare_pin_oe,
  output logic             timer_enable,
  output logic [15:0]      counter_value,
  output logic [15:0]      interval_load,
  output logic [7:0]       prescale_value,
  output logic [15:0]      captured_count,
  output logic             count_match_raw_status,
  output logic             count_match_masked_status,
  output logic             capture_event_raw_status,
  output logic             capture_event_masked_status,
  output logic             timeout_raw_status,
  output logic             timeout_masked_status
);

  localparam int CW = sbcpt_pkg::CNT_W;
  localparam int PW = sbcpt_pkg::PRE_W;
  localparam int SN = sbcpt_pkg::ST_N;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] load_r;
  logic [CW-1:0] cap_r;
  logic [CW-1:0] cap_nxt;
  logic [PW-1:0] presc_r;
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic          en_r;
  logic          en_nxt;
  logic          pwm_r;
  logic          pwm_nxt;
  logic          ccp_out_r;
  logic          ccp_oe_r;
  logic [SN-1:0] st_set;
  logic [SN-1:0] raw_r;
  logic [SN-1:0] msk_r;
  logic          pin_rise;
  logic          pin_fall;

  // ==========================================================
  // Pin synchroniser and edge detector
  sbcpt_pin_sync u_sync (
    .core_clk   (core_clk),
    .srst       (srst),
    .pin_async  (capture_compare_pin_in),
    .rise_pulse (pin_rise),
    .fall_pulse (pin_fall)
  );

  // ==========================================================
  // Mode decode
  wire cfg_ok    = (split_config == sbcpt_pkg::CFG_SPLIT);
  wire mode_per  = (timer_mode_field == sbcpt_pkg::MODE_PER);
  wire mode_one  = (timer_mode_field == sbcpt_pkg::MODE_ONE);
  wire mode_cap  = (timer_mode_field == sbcpt_pkg::MODE_CAP);
  wire pwm_sel   = cfg_ok & mode_per & alternate_mode_select
                 & ~capture_mode_select;
  wire timed_sel = cfg_ok & (mode_one | mode_per) & ~pwm_sel;
  wire count_sel = cfg_ok & mode_cap & ~capture_mode_select;
  wire time_sel  = cfg_ok & mode_cap & capture_mode_select;
  wire run_w     = en_r & ~stall_freeze;

  // Edge selection; edge time never takes both edges
  wire ev_rise   = (edge_event_select == sbcpt_pkg::EVT_RISE)
                 | (edge_event_select == sbcpt_pkg::EVT_BOTH);
  wire ev_fall   = (edge_event_select == sbcpt_pkg::EVT_FALL)
                 | ((edge_event_select == sbcpt_pkg::EVT_BOTH)
                    & ~time_sel);
  wire edge_w    = (pin_rise & ev_rise) | (pin_fall & ev_fall);

  // Shared counter terms
  wire [CW-1:0] dec_w    = cnt_r - sbcpt_pkg::CNT_ONE;
  wire          zero_w   = (cnt_r == sbcpt_pkg::CNT_ZERO);
  wire          pre_zero = (pre_r == sbcpt_pkg::PRE_ZERO);
  wire          cm_hit   = run_w & count_sel & edge_w
                         & (dec_w == match_value);
  wire          cap_evt  = run_w & time_sel & edge_w;

  // ==========================================================
  // Next-state of counter, prescaler, enable and capture
  always_comb begin
    cnt_nxt = cnt_r;
    pre_nxt = pre_r;
    cap_nxt = cap_r;
    en_nxt  = en_r;
    st_set  = '0;
    if (timer_enable_set) begin
      en_nxt = 1'b1;
    end
    if (timer_enable_clr) begin
      en_nxt = 1'b0;
    end
    if (run_w && timed_sel) begin
      if (!pre_zero) begin
        pre_nxt = pre_r - sbcpt_pkg::PRE_ONE;
      end else if (zero_w) begin
        cnt_nxt = load_r;
        pre_nxt = presc_r;
        st_set[sbcpt_pkg::ST_TO] = 1'b1;
        if (mode_one) begin
          en_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = dec_w;
        pre_nxt = presc_r;
      end
    end
    if (run_w && (pwm_sel || time_sel)) begin
      cnt_nxt = zero_w ? load_r : dec_w;
    end
    if (run_w && count_sel && edge_w) begin
      if (cm_hit) begin
        cnt_nxt = load_r;
        en_nxt  = 1'b0;
        st_set[sbcpt_pkg::ST_CM] = 1'b1;
      end else begin
        cnt_nxt = dec_w;
      end
    end
    if (cap_evt) begin
      cap_nxt = cnt_r;
      st_set[sbcpt_pkg::ST_CE] = 1'b1;
    end
    if (interval_load_wr) begin
      cnt_nxt = interval_load_wdata;
    end
  end

  // PWM level: active at load value, inactive at match value
  always_comb begin
    pwm_nxt = pwm_r;
    if (!pwm_sel) begin
      pwm_nxt = 1'b0;
    end else if (cnt_r == load_r) begin
      pwm_nxt = 1'b1;
    end else if (cnt_r == match_value) begin
      pwm_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Core registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_r   <= sbcpt_pkg::CNT_RST;
      load_r  <= sbcpt_pkg::CNT_RST;
      presc_r <= sbcpt_pkg::PRE_RST;
      pre_r   <= sbcpt_pkg::PRE_RST;
      cap_r   <= sbcpt_pkg::CNT_RST;
      en_r    <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      load_r  <= interval_load_wr ? interval_load_wdata : load_r;
      presc_r <= prescale_wr ? prescale_wdata : presc_r;
      pre_r   <= pre_nxt;
      cap_r   <= cap_nxt;
      en_r    <= en_nxt;
    end
  end

  // PWM pin drive, inverted on request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwm_r     <= 1'b0;
      ccp_out_r <= 1'b0;
      ccp_oe_r  <= 1'b0;
    end else begin
      pwm_r     <= pwm_nxt;
      ccp_out_r <= pwm_sel & (pwm_nxt ^ pwm_output_invert);
      ccp_oe_r  <= pwm_sel;
    end
  end

  // ==========================================================
  // Sticky status bits: a set in the clear cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < SN; gi++) begin : g_st
      always_ff @(posedge core_clk) begin
        if (srst) begin
          raw_r[gi] <= 1'b0;
          msk_r[gi] <= 1'b0;
        end else begin
          raw_r[gi] <= st_set[gi] | (raw_r[gi] & ~status_clear[gi]);
          msk_r[gi] <= (st_set[gi] | (raw_r[gi] & ~status_clear[gi]))
                       & status_mask[gi];
        end
      end
    end
  endgenerate

  // Spare status position never sets
  wire unused_spare = raw_r[sbcpt_pkg::ST_SP] | msk_r[sbcpt_pkg::ST_SP];

  // ==========================================================
  // Outputs, each straight from a flop
  assign capture_compare_pin_out     = ccp_out_r;
  assign capture_compare_pin_oe      = ccp_oe_r;
  assign timer_enable                = en_r;
  assign counter_value               = cnt_r;
  assign interval_load               = load_r;
  assign prescale_value              = presc_r;
  assign captured_count              = cap_r;
  assign count_match_raw_status      = raw_r[sbcpt_pkg::ST_CM];
  assign count_match_masked_status   = msk_r[sbcpt_pkg::ST_CM];
  assign capture_event_raw_status    = raw_r[sbcpt_pkg::ST_CE];
  assign capture_event_masked_status = msk_r[sbcpt_pkg::ST_CE];
  assign timeout_raw_status          = raw_r[sbcpt_pkg::ST_TO];
  assign timeout_masked_status       = msk_r[sbcpt_pkg::ST_TO];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_reload;
    interval_load_wr |=> counter_value == $past(interval_load_wdata);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Interval load not adopted next cycle");

  property p_stall;
    stall_freeze && !interval_load_wr |=> $stable(counter_value);
  endproperty
  a_stall: assert property (p_stall)
    else $error("Counter moved during stall");

  property p_prescale_hold;
    run_w && timed_sel && !pre_zero && !interval_load_wr
      |=> $stable(counter_value)
      && (pre_r == $past(pre_r) - sbcpt_pkg::PRE_ONE);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold)
    else $error("Counter moved before prescale expired");

  property p_bypass;
    run_w && (pwm_sel || time_sel) && !zero_w && !interval_load_wr
      |=> counter_value == $past(counter_value) - sbcpt_pkg::CNT_ONE;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Prescaler not bypassed");

  property p_count_match;
    cm_hit && !interval_load_wr |=> count_match_raw_status
      && !timer_enable && (counter_value == $past(interval_load));
  endproperty
  a_count_match: assert property (p_count_match)
    else $error("Edge count match did not reload and stop");

  property p_capture;
    cap_evt |=> (captured_count == $past(counter_value))
      && capture_event_raw_status;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Edge not captured");

  property p_cap_hold;
    !cap_evt |=> $stable(captured_count);
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("Captured count changed without an edge");

  property p_pwm_quiet;
    pwm_sel && !raw_r[sbcpt_pkg::ST_CM] && !raw_r[sbcpt_pkg::ST_CE]
      && !raw_r[sbcpt_pkg::ST_TO]
      |=> !count_match_raw_status && !capture_event_raw_status
      && !timeout_raw_status;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet)
    else $error("Status raised in PWM mode");

  property p_pwm_active;
    pwm_sel && (counter_value == interval_load)
      |=> capture_compare_pin_out == !$past(pwm_output_invert);
  endproperty
  a_pwm_active: assert property (p_pwm_active)
    else $error("PWM not active at load value");

  property p_pwm_inactive;
    pwm_sel && (counter_value != interval_load)
      && (counter_value == match_value)
      |=> capture_compare_pin_out == $past(pwm_output_invert);
  endproperty
  a_pwm_inactive: assert property (p_pwm_inactive)
    else $error("PWM not inactive at match value");

  property p_timeout;
    run_w && timed_sel && pre_zero && zero_w && mode_one
      && !interval_load_wr |=> timeout_raw_status && !timer_enable
      && (counter_value == interval_load);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("One-shot timeout did not reload and stop");

  property p_reset_vals;
    $past(srst) |-> (counter_value == sbcpt_pkg::CNT_RST)
      && (interval_load == sbcpt_pkg::CNT_RST)
      && (prescale_value == sbcpt_pkg::PRE_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Wrong values after reset");

  c_count_match: cover property (cm_hit);
  c_capture:     cover property (cap_evt ##[1:200] cap_evt);
  c_pwm_edge:    cover property (pwm_sel && $rose(ccp_out_r));
  c_timeout:     cover property ($rose(timeout_raw_status));

endmodule : sbcpt_timer

// ==== tb_top.sv ====
// Self-checking bench for the 16-bit capture and PWM timer
`timescale 1ns/1ps

module tb_top;
  typedef struct {int sel; logic [15:0] exp;} sbcpt_note_s;
  logic core_clk = 1'b0, srst = 1'b1;
  logic [2:0] split_config = 3'h4;
  logic [1:0] timer_mode_field = 2'h2, edge_event_select = 2'h0;
  logic capture_mode_select = 1'b0, alternate_mode_select = 1'b0;
  logic pwm_output_invert = 1'b0, stall_freeze = 1'b0;
  logic timer_enable_set = 1'b0, timer_enable_clr = 1'b0;
  logic interval_load_wr = 1'b0, prescale_wr = 1'b0;
  logic [15:0] interval_load_wdata = 16'h0000, match_value = 16'h0000;
  logic [7:0] prescale_wdata = 8'h00;
  logic [3:0] status_mask = 4'h0, status_clear = 4'h0;
  logic capture_compare_pin_in, capture_compare_pin_out;
  logic capture_compare_pin_oe, timer_enable;
  logic [15:0] counter_value, interval_load, captured_count;
  logic [7:0] prescale_value;
  logic count_match_raw_status, count_match_masked_status;
  logic capture_event_raw_status, capture_event_masked_status;
  logic timeout_raw_status, timeout_masked_status;
  int failures = 0, n_checks = 0, seed = 32'hcd3e;
  sbcpt_note_s notes[$];
  string nm[12] = '{"cnt", "load", "pre", "cap", "en", "pwm", "oe",
                    "cm_raw", "cm_masked", "ce_raw", "ce_masked", "to_raw"};
  wire [7:0] flags = {timeout_raw_status, capture_event_masked_status,
    capture_event_raw_status, count_match_masked_status,
    count_match_raw_status, capture_compare_pin_oe,
    capture_compare_pin_out, timer_enable};

  // ==========================================================
  // Design, pin source and clock
  sbcpt_timer i_dut (.core_clk, .srst, .split_config, .timer_mode_field,
    .capture_mode_select, .alternate_mode_select, .edge_event_select,
    .pwm_output_invert, .stall_freeze, .timer_enable_set,
    .timer_enable_clr, .interval_load_wr, .interval_load_wdata,
    .prescale_wr, .prescale_wdata, .match_value, .status_mask,
    .status_clear, .capture_compare_pin_in, .capture_compare_pin_out,
    .capture_compare_pin_oe, .timer_enable, .counter_value, .interval_load,
    .prescale_value, .captured_count, .count_match_raw_status,
    .count_match_masked_status, .capture_event_raw_status,
    .capture_event_masked_status, .timeout_raw_status,
    .timeout_masked_status);
  sbcpt_edge_src i_src (.core_clk, .pin_out(capture_compare_pin_out),
    .pin_oe(capture_compare_pin_oe), .pin_in(capture_compare_pin_in));

  always #4 core_clk = ~core_clk;

  // ==========================================================
  // Checking helpers
  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: obs = counter_value;
      1: obs = interval_load;
      2: obs = {8'h00, prescale_value};
      3: obs = captured_count;
      default: obs = {15'h0000, flags[sel-4]};
    endcase
  endfunction : obs

  task automatic chk(input string n, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic note(input int sel, input logic [15:0] exp);
    notes.push_back('{sel, exp});
  endtask : note

  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // Every queued note is compared against the outputs settled before this edge
  always @(posedge core_clk) begin : mon
    sbcpt_note_s cur;
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      chk(nm[cur.sel], obs(cur.sel), cur.exp);
    end
  end

  task automatic wait_hi(input int sel, input int lim);
    repeat (lim) begin
      @(negedge core_clk);
      if (obs(sel) === 16'h0001) return;
    end
    failures++;
    end_of_test();
  endtask : wait_hi

  // Clocks from the current sample until the counter moves
  task automatic step_len(output int n);
    logic [15:0] c;
    n = 0;
    c = counter_value;
    while (counter_value === c && n < 600) begin
      @(negedge core_clk);
      n++;
    end
    if (counter_value === c) begin
      failures++;
      end_of_test();
    end
  endtask : step_len

  // ==========================================================
  // Control strobes, one cycle each
  task automatic load(input logic [15:0] v);
    @(posedge core_clk);
    interval_load_wr <= 1'b1;
    interval_load_wdata <= v;
    @(posedge core_clk);
    interval_load_wr <= 1'b0;
  endtask : load

  task automatic en(input logic on);
    @(posedge core_clk);
    timer_enable_set <= on;
    timer_enable_clr <= ~on;
    @(posedge core_clk);
    timer_enable_set <= 1'b0;
    timer_enable_clr <= 1'b0;
  endtask : en

  task automatic sclear(input logic [3:0] m);
    @(posedge core_clk);
    status_clear <= m;
    @(posedge core_clk);
    status_clear <= 4'h0;
  endtask : sclear

  task automatic prescale(input logic [7:0] p);
    @(posedge core_clk);
    prescale_wr <= 1'b1;
    prescale_wdata <= p;
    @(posedge core_clk);
    prescale_wr <= 1'b0;
  endtask : prescale

  // ==========================================================
  // Main sequence
  initial begin : main
    int n;
    logic [15:0] v;
    logic [7:0] pre_tab[3] = '{8'hff, 8'h02, 8'h00};
    logic [1:0] evt_tab[3] = '{2'h0, 2'h1, 2'h3};
    int nfl[3] = '{4, 4, 2};
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    note(0, sbcpt_pkg::CNT_RST);
    note(1, sbcpt_pkg::CNT_RST);
    note(2, {8'h00, sbcpt_pkg::PRE_RST});
    note(4, 16'h0000);
    // Periodic timing: decrement spacing follows the prescale
    @(posedge core_clk);
    status_mask <= 4'h7;
    foreach (pre_tab[i]) begin
      prescale(pre_tab[i]);
      en(1'b1);
      @(negedge core_clk);
      step_len(n);
      step_len(n);
      chk("step", 16'(n), {8'h00, pre_tab[i]} + 16'h0001);
      note(2, {8'h00, pre_tab[i]});
      en(1'b0);
    end
    // Stall holds the count; load while running is taken next cycle
    en(1'b1);
    @(posedge core_clk);
    stall_freeze <= 1'b1;
    repeat (2) @(negedge core_clk);
    v = counter_value;
    repeat (6) @(negedge core_clk);
    note(0, v);
    @(posedge core_clk);
    stall_freeze <= 1'b0;
    v = {1'b1, 15'($random(seed))};
    load(v);
    @(negedge core_clk);
    note(0, v);
    note(1, v);
    // One-shot expiry: reload, self-disable, timeout status
    en(1'b0);
    @(posedge core_clk);
    timer_mode_field <= sbcpt_pkg::MODE_ONE;
    load(16'h0005);
    sclear(4'h4);
    en(1'b1);
    wait_hi(11, 40);
    chk("to_masked", {15'h0000, timeout_masked_status}, 16'h0001);
    note(4, 16'h0000);
    note(0, 16'h0005);
    // Edge counting for rise, fall and both
    @(posedge core_clk);
    timer_mode_field <= sbcpt_pkg::MODE_CAP;
    match_value <= 16'h0006;
    foreach (evt_tab[i]) begin
      @(posedge core_clk);
      edge_event_select <= evt_tab[i];
      load(16'h000A);
      sclear(4'h1);
      en(1'b1);
      for (int j = 0; j < 3; j++) begin
        repeat (nfl[i]) i_src.flip($random(seed) & 3);
        repeat (6) @(negedge core_clk);
        if (j == 0) note(0, 16'h0008);
        if (j == 1) note(4, 16'h0000);
        if (j == 1) note(7, 16'h0001);
        if (j == 1) note(8, 16'h0001);
        if (j > 0) note(0, 16'h000A);
      end
    end
    // Edge timing: capture on rise only, masked flag held low
    en(1'b0);
    prescale(8'h05);
    @(posedge core_clk);
    capture_mode_select <= 1'b1;
    edge_event_select <= sbcpt_pkg::EVT_RISE;
    status_mask <= 4'h5;
    load(16'hffff);
    sclear(4'h2);
    en(1'b1);
    for (int j = 0; j < 2; j++) begin
      i_src.flip(2);
      wait_hi(9, 20);
      chk("cap", captured_count, counter_value + 16'h0001);
      note(10, 16'h0000);
      v = captured_count;
      sclear(4'h2);
      i_src.flip(3);
      repeat (6) @(negedge core_clk);
      note(3, v);
      note(9, 16'h0000);
      // Second pass asks for both edges; only the rise may capture
      @(posedge core_clk);
      edge_event_select <= sbcpt_pkg::EVT_BOTH;
    end
    load(16'h0003);
    for (int k = 0; k < 6; k++) begin
      @(negedge core_clk);
      note(0, 16'h0003 - 16'(k % 4));
    end
    // PWM at both polarities, period 10, active 6
    en(1'b0);
    @(posedge core_clk);
    capture_mode_select <= 1'b0;
    alternate_mode_select <= 1'b1;
    timer_mode_field <= sbcpt_pkg::MODE_PER;
    match_value <= 16'h0003;
    load(16'h0009);
    sclear(4'hf);
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      pwm_output_invert <= p[0];
      en(1'b1);
      repeat (12) @(negedge core_clk);
      n = 0;
      repeat (20) begin
        @(negedge core_clk);
        n += int'(capture_compare_pin_out === 1'b1);
      end
      note(6, 16'h0001);
      chk("pwm_high", 16'(n), p ? 16'h0008 : 16'h000c);
      note(7, 16'h0000);
      note(9, 16'h0000);
      note(11, 16'h0000);
      en(1'b0);
    end
    repeat (2) @(negedge core_clk);
    end_of_test();
  end

endmodule : tb_top
